// [rtl/rsd_rx_desc_dma.sv]
/*
  Receive descriptor walker: follows the linked descriptor list in host
  memory, scatters received frame bytes into the fragments and writes back
  the status word of each descriptor it used.
  Assumes a host memory port that holds a request until a one-cycle
  acknowledge, and a byte stream from logic on the same clock.
*/
`default_nettype none

module rsd_rx_desc_dma (
  input wire logic clk_i, // System clock, 50 MHz
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic en_i, // Clock enable, freezes all state when low
  input wire logic start_i, // Pulse: load list head and start walking
  input wire logic [39:0] list_head_i, // First descriptor address
  input wire logic [3:0] frag_count_i, // Fragments per descriptor, 1..15
  input wire logic [15:0] frame_size_limit_i, // Largest allowed frame
  input wire logic rx_valid_i, // Received byte valid
  input wire logic [7:0] rx_data_i, // Received byte
  input wire logic rx_last_i, // Byte closes the frame
  input wire rsd_pkg::rsd_rx_info_s rx_info_i, // Frame flags, read with last
  output var logic rx_ready_o, // Byte taken when valid and ready
  output rsd_pkg::rsd_mem_s mem_o, // Host memory request
  input wire logic mem_ack_i, // Request done, one-cycle pulse
  input wire logic [63:0] mem_rdata_i, // Read data, valid with ack
  output var logic busy_o, // Walker active
  output var logic stalled_o, // Waiting for software to free a descriptor
  output var logic list_empty_o // Walker stopped on a null pointer
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    rsd_pkg::rsd_state_e state;
    logic [39:0] desc;
    logic [39:0] next_ptr;
    rsd_pkg::rsd_frag_s frag;
    logic [3:0] idx;
    logic [15:0] flen;
    logic first;
    logic last_seen;
    rsd_pkg::rsd_rx_info_s info;
    rsd_pkg::rsd_mem_s mem;
    logic rx_ready;
    logic busy;
    logic stalled;
    logic empty;
  } rsd_ctl_s;

  rsd_ctl_s st_ff;
  rsd_ctl_s nxt_st;
  rsd_pkg::rsd_frag_s rd_frag;
  logic [63:0] stat_word;
  logic [3:0] frag_cnt;
  logic byte_take;
  logic ack;

  rsd_frag_decode u_frag_decode (
    .entry_i (mem_rdata_i),
    .frag_o (rd_frag)
  );

  rsd_status_pack u_status_pack (
    .flen_i (st_ff.flen),
    .first_i (st_ff.first),
    .last_i (st_ff.last_seen),
    .info_i (st_ff.info),
    .limit_i (frame_size_limit_i),
    .word_o (stat_word)
  );

  function automatic rsd_pkg::rsd_mem_s mem_op(input logic we, input logic [39:0] addr,
                                               input logic [63:0] wdata,
                                               input logic [7:0] be);
    rsd_pkg::rsd_mem_s m;
    m.req = 1'b1;
    m.we = we;
    m.addr = addr;
    m.wdata = wdata;
    m.be = be;
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // A count of zero would leave no place for data, so it acts as one.
  assign frag_cnt = (frag_count_i == 4'h0) ? 4'h1 :
                    (frag_count_i > rsd_pkg::RSD_FRAG_LAST_IDX + 4'h1) ?
                    rsd_pkg::RSD_FRAG_LAST_IDX + 4'h1 : frag_count_i;
  assign ack = st_ff.mem.req & mem_ack_i;
  assign byte_take = st_ff.rx_ready & rx_valid_i;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.busy = 1'b1;
    unique case (st_ff.state)
      rsd_pkg::RSD_ST_IDLE: begin
        nxt_st.busy = 1'b0;
        if (start_i) begin
          nxt_st.desc = list_head_i;
          if (list_head_i == rsd_pkg::RSD_NULL_PTR) begin
            nxt_st.empty = 1'b1;
          end else begin
            nxt_st.empty = 1'b0;
            nxt_st.busy = 1'b1;
            nxt_st.state = rsd_pkg::RSD_ST_RD_STAT;
          end
        end
      end
      rsd_pkg::RSD_ST_RD_STAT: begin
        // Polling the status word again is how the stall ends: nothing
        // else tells the walker that software gave the descriptor back.
        if (!st_ff.mem.req) begin
          nxt_st.mem = mem_op(1'b0, 40'(st_ff.desc + rsd_pkg::RSD_OFS_STAT), '0,
                              rsd_pkg::RSD_BE_ALL);
        end else if (mem_ack_i) begin
          nxt_st.mem.req = 1'b0;
          if (mem_rdata_i[rsd_pkg::RSD_BIT_OWNED]) begin
            nxt_st.stalled = 1'b1;
          end else begin
            nxt_st.stalled = 1'b0;
            nxt_st.state = rsd_pkg::RSD_ST_RD_NEXT;
          end
        end
      end
      rsd_pkg::RSD_ST_RD_NEXT: begin
        if (!st_ff.mem.req) begin
          nxt_st.mem = mem_op(1'b0, 40'(st_ff.desc + rsd_pkg::RSD_OFS_NEXT), '0,
                              rsd_pkg::RSD_BE_ALL);
        end else if (mem_ack_i) begin
          nxt_st.mem.req = 1'b0;
          nxt_st.next_ptr = mem_rdata_i[rsd_pkg::RSD_ADDR_MSB:0];
          nxt_st.idx = 4'h0;
          nxt_st.state = rsd_pkg::RSD_ST_RD_FRAG;
        end
      end
      rsd_pkg::RSD_ST_RD_FRAG: begin
        if (!st_ff.mem.req) begin
          nxt_st.mem = mem_op(1'b0, 40'(st_ff.desc + rsd_pkg::RSD_OFS_FRAG0 +
                              40'(st_ff.idx) * rsd_pkg::RSD_FRAG_STRIDE), '0,
                              rsd_pkg::RSD_BE_ALL);
        end else if (mem_ack_i) begin
          nxt_st.mem.req = 1'b0;
          nxt_st.frag = rd_frag;
          if (rd_frag.len != 17'h0_0000) begin
            nxt_st.state = rsd_pkg::RSD_ST_DATA;
          end else if (st_ff.idx + 4'h1 < frag_cnt) begin
            nxt_st.idx = st_ff.idx + 4'h1;
          end else begin
            nxt_st.state = rsd_pkg::RSD_ST_WR_STAT;
          end
        end
      end
      rsd_pkg::RSD_ST_DATA: begin
        // One byte per write keeps any fragment alignment legal, at the
        // cost of bus efficiency.
        if (!st_ff.mem.req) begin
          nxt_st.rx_ready = 1'b1;
          if (byte_take) begin
            nxt_st.rx_ready = 1'b0;
            nxt_st.mem = mem_op(1'b1, st_ff.frag.addr, {8{rx_data_i}},
                                8'(rsd_pkg::RSD_BE_BYTE0 << st_ff.frag.addr[2:0]));
            nxt_st.flen = st_ff.flen + 16'h0001;
            nxt_st.last_seen = rx_last_i;
            if (rx_last_i) begin
              nxt_st.info = rx_info_i;
            end
          end
        end else if (mem_ack_i) begin
          nxt_st.mem.req = 1'b0;
          nxt_st.rx_ready = 1'b0;
          nxt_st.frag.addr = st_ff.frag.addr + 40'h00_0000_0001;
          nxt_st.frag.len = st_ff.frag.len - 17'h0_0001;
          if (st_ff.last_seen) begin
            nxt_st.state = rsd_pkg::RSD_ST_WR_STAT;
          end else if (st_ff.frag.len == 17'h0_0001) begin
            if (st_ff.idx + 4'h1 < frag_cnt) begin
              nxt_st.idx = st_ff.idx + 4'h1;
              nxt_st.state = rsd_pkg::RSD_ST_RD_FRAG;
            end else begin
              nxt_st.state = rsd_pkg::RSD_ST_WR_STAT;
            end
          end
        end
      end
      rsd_pkg::RSD_ST_WR_STAT: begin
        if (!st_ff.mem.req) begin
          nxt_st.mem = mem_op(1'b1, 40'(st_ff.desc + rsd_pkg::RSD_OFS_STAT), stat_word,
                              rsd_pkg::RSD_BE_ALL);
        end else if (mem_ack_i) begin
          nxt_st.mem.req = 1'b0;
          nxt_st.first = st_ff.last_seen;
          if (st_ff.last_seen) begin
            nxt_st.flen = 16'h0000;
            nxt_st.last_seen = 1'b0;
          end
          nxt_st.desc = st_ff.next_ptr;
          if (st_ff.next_ptr == rsd_pkg::RSD_NULL_PTR) begin
            nxt_st.empty = 1'b1;
            nxt_st.busy = 1'b0;
            nxt_st.state = rsd_pkg::RSD_ST_IDLE;
          end else begin
            nxt_st.state = rsd_pkg::RSD_ST_RD_STAT;
          end
        end
      end
      default: begin
        nxt_st.state = rsd_pkg::RSD_ST_IDLE;
        nxt_st.mem.req = 1'b0;
        nxt_st.rx_ready = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.state <= rsd_pkg::RSD_ST_IDLE;
      st_ff.first <= 1'b1;
    end else if (en_i) begin
      st_ff <= nxt_st;
    end
  end

  assign rx_ready_o = st_ff.rx_ready;
  assign mem_o = st_ff.mem;
  assign busy_o = st_ff.busy;
  assign stalled_o = st_ff.stalled;
  assign list_empty_o = st_ff.empty;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_owned_seen;
    en_i && ack && st_ff.state == rsd_pkg::RSD_ST_RD_STAT &&
      mem_rdata_i[rsd_pkg::RSD_BIT_OWNED];
  endsequence

  sequence s_stat_write;
    mem_o.req && st_ff.state == rsd_pkg::RSD_ST_WR_STAT;
  endsequence

  sequence s_last_byte_done;
    en_i && ack && st_ff.state == rsd_pkg::RSD_ST_DATA && st_ff.last_seen;
  endsequence

  a_stall_owned_desc: assert property (s_owned_seen |=> stalled_o &&
      st_ff.state == rsd_pkg::RSD_ST_RD_STAT ##1 en_i |=> mem_o.req && !mem_o.we)
    else $error("Owned descriptor did not stall the walker.");

  a_frag_entry_addr: assert property (mem_o.req &&
      st_ff.state == rsd_pkg::RSD_ST_RD_FRAG |-> st_ff.idx <= 4'hE &&
      mem_o.addr == 40'(st_ff.desc + 40'h00_0000_0010 + 40'(st_ff.idx) * 40'h00_0000_0008))
    else $error("Fragment entry read from a wrong address.");

  a_stat_owned_set: assert property (s_stat_write |-> mem_o.we &&
      mem_o.wdata[31] && mem_o.addr == 40'(st_ff.desc + 40'h00_0000_0008))
    else $error("Status write lacks the ownership bit.");

  a_mid_len_zero: assert property ((s_stat_write and !mem_o.wdata[30]) |->
      mem_o.wdata[15:0] == 16'h0000 && mem_o.wdata[27:16] == 12'h000)
    else $error("Non-closing descriptor carries length or flags.");

  a_short_no_mismatch: assert property ((s_stat_write and mem_o.wdata[17]) |->
      !mem_o.wdata[21] && mem_o.wdata[15:0] < 16'h003C)
    else $error("Short frame reported with a length mismatch.");

  a_byte_to_frag: assert property (en_i && !st_ff.mem.req && byte_take &&
      st_ff.state == rsd_pkg::RSD_ST_DATA |=> mem_o.req && mem_o.we &&
      mem_o.addr == $past(st_ff.frag.addr) && !rx_ready_o)
    else $error("Accepted byte not written to the fragment.");

  a_hold_request: assert property (mem_o.req && !mem_ack_i |=>
      mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we))
    else $error("Memory request dropped or changed before acknowledge.");

  a_null_ptr_halt: assert property (en_i && ack && st_ff.next_ptr == 40'h00_0000_0000 &&
      st_ff.state == rsd_pkg::RSD_ST_WR_STAT |=> list_empty_o && !busy_o ##1 !mem_o.req)
    else $error("Walker did not stop on a null next pointer.");

  a_status_after_data: assert property (s_last_byte_done |=>
      st_ff.state == rsd_pkg::RSD_ST_WR_STAT ##1 mem_o.req || !en_i)
    else $error("Status not written after the closing byte.");

  a_first_after_last: assert property ((s_stat_write and (mem_ack_i && en_i &&
      mem_o.wdata[30])) |=> st_ff.first && st_ff.flen == 16'h0000)
    else $error("Next frame not marked as first.");

endmodule

`default_nettype wire

// [common/rsd_pkg.sv]
/*
  Package for the receive descriptor walker: descriptor layout, status word
  field positions, state encoding and the structs that carry related signals.
  Assumes descriptors live in a 40-bit byte-addressed host memory reached by
  a 64-bit word port with byte enables.
*/
`default_nettype none

package rsd_pkg;

  // ----------------------------------------------------------------------
  // Descriptor layout
  // ----------------------------------------------------------------------
  localparam logic [39:0] RSD_OFS_NEXT = 40'h00_0000_0000;
  localparam logic [39:0] RSD_OFS_STAT = 40'h00_0000_0008;
  localparam logic [39:0] RSD_OFS_FRAG0 = 40'h00_0000_0010;
  localparam logic [39:0] RSD_FRAG_STRIDE = 40'h00_0000_0008;
  localparam logic [3:0] RSD_FRAG_LAST_IDX = 4'hE;
  localparam logic [39:0] RSD_NULL_PTR = 40'h00_0000_0000;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RSD_ADDR_MSB = 39;
  localparam int RSD_FLEN_LSB = 48;
  localparam int RSD_FLEN_MSB = 63;
  localparam int RSD_BIT_OVERFLOW = 16;
  localparam int RSD_BIT_SHORT = 17;
  localparam int RSD_BIT_MISALIGNED = 18;
  localparam int RSD_BIT_CHECK_BAD = 19;
  localparam int RSD_BIT_TOO_LONG = 20;
  localparam int RSD_BIT_LEN_MISMATCH = 21;
  localparam int RSD_BIT_TAG = 22;
  localparam int RSD_BIT_TCP = 23;
  localparam int RSD_BIT_TCP_BAD = 24;
  localparam int RSD_BIT_UDP = 25;
  localparam int RSD_BIT_UDP_BAD = 26;
  localparam int RSD_BIT_IP = 27;
  localparam int RSD_BIT_FIRST = 29;
  localparam int RSD_BIT_LAST = 30;
  localparam int RSD_BIT_OWNED = 31;

  // ----------------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RSD_SHORT_MIN = 16'h003C;
  localparam logic [7:0] RSD_BE_ALL = 8'hFF;
  localparam logic [7:0] RSD_BE_BYTE0 = 8'h01;

  typedef enum logic [6:0] {
    RSD_ST_IDLE = 7'b000_0001,
    RSD_ST_RD_STAT = 7'b000_0010,
    RSD_ST_RD_NEXT = 7'b000_0100,
    RSD_ST_RD_FRAG = 7'b000_1000,
    RSD_ST_DATA = 7'b001_0000,
    RSD_ST_WR_STAT = 7'b010_0000,
    RSD_ST_SPARE = 7'b100_0000
  } rsd_state_e;

  typedef struct packed {
    logic overflow;
    logic misaligned;
    logic check_bad;
    logic len_mismatch;
    logic tag;
    logic tcp;
    logic tcp_bad;
    logic udp;
    logic udp_bad;
    logic ip;
  } rsd_rx_info_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [39:0] addr;
    logic [63:0] wdata;
    logic [7:0] be;
  } rsd_mem_s;

  typedef struct packed {
    logic [39:0] addr;
    logic [16:0] len;
  } rsd_frag_s;

endpackage

`default_nettype wire

// [rtl/rsd_frag_decode.sv]
/*
  Splits one 64-bit fragment entry into start address and byte length.
  Assumes the entry comes straight from a host memory read.
*/
`default_nettype none

module rsd_frag_decode (
  input wire logic [63:0] entry_i, // Raw fragment entry
  output rsd_pkg::rsd_frag_s frag_o // Address and length
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Bits 47..40 are never looked at, whatever software left there.
  always_comb begin
    frag_o.addr = entry_i[rsd_pkg::RSD_ADDR_MSB:0];
    frag_o.len = {1'b0, entry_i[rsd_pkg::RSD_FLEN_MSB:rsd_pkg::RSD_FLEN_LSB]};
  end

endmodule

`default_nettype wire

// [rtl/rsd_status_pack.sv]
/*
  Builds the 64-bit receive status word written back into a descriptor.
  Assumes the frame length and flags are stable while the write is pending.
*/
`default_nettype none

module rsd_status_pack (
  input wire logic [15:0] flen_i, // Bytes of the frame so far
  input wire logic first_i, // Descriptor opens the frame
  input wire logic last_i, // Descriptor closes the frame
  input wire rsd_pkg::rsd_rx_info_s info_i, // Flags from the receiver
  input wire logic [15:0] limit_i, // Largest allowed frame size
  output logic [63:0] word_o // Status word
);

  logic is_short;

  // ----------------------------------------------------------------------
  // Pack
  // ----------------------------------------------------------------------
  // Flags are only meaningful in the closing descriptor, so the others
  // carry zeros there rather than stale values.
  always_comb begin
    is_short = flen_i < rsd_pkg::RSD_SHORT_MIN;
    word_o = '0;
    if (last_i) begin
      word_o[15:0] = flen_i;
      word_o[rsd_pkg::RSD_BIT_OVERFLOW] = info_i.overflow;
      word_o[rsd_pkg::RSD_BIT_SHORT] = is_short;
      word_o[rsd_pkg::RSD_BIT_MISALIGNED] = info_i.misaligned;
      word_o[rsd_pkg::RSD_BIT_CHECK_BAD] = info_i.check_bad;
      word_o[rsd_pkg::RSD_BIT_TOO_LONG] = flen_i > limit_i;
      word_o[rsd_pkg::RSD_BIT_LEN_MISMATCH] = info_i.len_mismatch & ~is_short;
      word_o[rsd_pkg::RSD_BIT_TAG] = info_i.tag;
      word_o[rsd_pkg::RSD_BIT_TCP] = info_i.tcp;
      word_o[rsd_pkg::RSD_BIT_TCP_BAD] = info_i.tcp_bad;
      word_o[rsd_pkg::RSD_BIT_UDP] = info_i.udp;
      word_o[rsd_pkg::RSD_BIT_UDP_BAD] = info_i.udp_bad;
      word_o[rsd_pkg::RSD_BIT_IP] = info_i.ip;
    end
    word_o[rsd_pkg::RSD_BIT_FIRST] = first_i;
    word_o[rsd_pkg::RSD_BIT_LAST] = last_i;
    word_o[rsd_pkg::RSD_BIT_OWNED] = 1'b1;
  end

endmodule

`default_nettype wire

// [verification/rsd_host_mem_model.sv]
/*
  Behavioural host memory behind the descriptor walker's memory port.
  Assumes requests are held until a one-cycle acknowledge, as the walker does.
*/
`default_nettype none

module rsd_host_mem_model (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [3:0] wait_i, // Extra cycles before each acknowledge
  input wire rsd_pkg::rsd_mem_s mem_i, // Request from the walker
  output logic mem_ack_o, // One-cycle acknowledge
  output logic [63:0] mem_rdata_o // Read data, valid with acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [63:0] m [logic [36:0]];
  logic [3:0] cnt;

  function automatic logic [63:0] get(input logic [39:0] a);
    return m.exists(a[39:3]) ? m[a[39:3]] : 64'h0000_0000_0000_0000;
  endfunction

  function automatic void put(input logic [39:0] a, input logic [63:0] d);
    m[a[39:3]] = d;
  endfunction

  function automatic void wr(input rsd_pkg::rsd_mem_s r);
    logic [63:0] w;
    w = get(r.addr);
    for (int i = 0; i < 8; i++) begin
      if (r.be[i]) begin
        w[8*i +: 8] = r.wdata[8*i +: 8];
      end
    end
    put(r.addr, w);
  endfunction

  // Read data toggles on every cycle but a read acknowledge so a stale value can never look valid.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      mem_ack_o <= 1'b0;
      cnt <= 4'h0;
      mem_rdata_o <= 64'h0000_0000_0000_0000;
    end else begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_i.req && !mem_ack_o) begin
        if (cnt >= wait_i) begin
          mem_ack_o <= 1'b1;
          cnt <= 4'h0;
          if (mem_i.we) begin
            wr(mem_i);
          end else begin
            mem_rdata_o <= get(mem_i.addr);
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [verification/tb_rx_descriptor_status_dma.sv]
/*
  Self-checking bench for the receive descriptor walker.
  Assumes the host memory model of this folder and one 50 MHz clock.
*/
`default_nettype none

module tb_rx_descriptor_status_dma;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, rst_n_i, en_i, start_i, rx_valid_i, rx_last_i, mem_ack_i;
  logic rx_ready_o, busy_o, stalled_o, list_empty_o;
  logic [39:0] list_head_i;
  logic [3:0] frag_count_i, lat;
  logic [15:0] frame_size_limit_i;
  logic [7:0] rx_data_i;
  logic [63:0] mem_rdata_i;
  rsd_pkg::rsd_rx_info_s rx_info_i;
  rsd_pkg::rsd_mem_s mem_o;
  int failures, num_checks, cycles;

  rsd_rx_desc_dma dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .start_i(start_i),
    .list_head_i(list_head_i), .frag_count_i(frag_count_i),
    .frame_size_limit_i(frame_size_limit_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_last_i(rx_last_i), .rx_info_i(rx_info_i), .rx_ready_o(rx_ready_o), .mem_o(mem_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o),
    .stalled_o(stalled_o), .list_empty_o(list_empty_o));

  rsd_host_mem_model mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .wait_i(lat), .mem_i(mem_o),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic [39:0] a, input logic [7:0] exp);
    logic [63:0] w;
    w = mem.get(a);
    chk({56'h0, w[8*a[2:0] +: 8]}, {56'h0, exp});
  endtask

  // Reserved entry bits carry junk on purpose; the walker must not use them.
  task automatic frag(input logic [39:0] b, input int n, input logic [39:0] a,
                      input logic [15:0] len);
    mem.put(b + 40'h10 + 40'(n * 8), {len, 8'h5A, a});
  endtask

  task automatic start(input logic [39:0] h);
    @(posedge clk_i);
    start_i <= 1'b1;
    list_head_i <= h;
    @(posedge clk_i);
    start_i <= 1'b0;
  endtask

  task automatic send(input int n, input logic [7:0] b0, input logic [9:0] info);
    int w;
    @(posedge clk_i);
    rx_valid_i <= 1'b1;
    rx_data_i <= b0;
    rx_last_i <= (n == 1);
    rx_info_i <= rsd_pkg::rsd_rx_info_s'(info);
    for (int k = 0; k < n; k++) begin
      w = 0;
      @(negedge clk_i);
      while (rx_ready_o !== 1'b1 && w < 500) begin
        @(negedge clk_i);
        w++;
      end
      chk({63'h0, rx_ready_o}, 64'h1);
      @(posedge clk_i);
      rx_data_i <= b0 + 8'(k + 1);
      rx_last_i <= (k == n - 2);
      rx_valid_i <= (k < n - 1);
    end
  endtask

  // Sel 0 waits for the walker to go idle, sel 1 for it to stall.
  task automatic wait_for(input int sel);
    int w;
    w = 0;
    @(negedge clk_i);
    while (w < 3000 && (sel == 0 ? busy_o !== 1'b0 : stalled_o !== 1'b1)) begin
      @(negedge clk_i);
      w++;
    end
    if (sel == 0) begin
      chk({63'h0, busy_o}, 64'h0);
    end else begin
      chk({63'h0, stalled_o}, 64'h1);
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_single;
    frag_count_i <= 4'h2;
    frame_size_limit_i <= 16'h05DC;
    mem.put(40'h00_0000_1000, 64'h0);
    mem.put(40'h00_0000_1008, 64'h0);
    frag(40'h00_0000_1000, 0, 40'hF0_0000_0007, 16'h0003);
    frag(40'h00_0000_1000, 1, 40'h12_3456_7890, 16'h0004);
    start(40'h00_0000_1000);
    send(5, 8'h30, 10'h050);
    wait_for(0);
    for (int k = 0; k < 3; k++) chkb(40'hF0_0000_0007 + 40'(k), 8'h30 + 8'(k));
    chkb(40'hF0_0000_000A, 8'h00);
    for (int k = 0; k < 2; k++) chkb(40'h12_3456_7890 + 40'(k), 8'h33 + 8'(k));
    chk(mem.get(40'h00_0000_1008), 64'h0000_0000_E082_0005);
    chk({63'h0, list_empty_o}, 64'h1);
  endtask

  task automatic t_span;
    logic [39:0] a;
    frag_count_i <= 4'h1;
    frame_size_limit_i <= 16'h0032;
    mem.put(40'h00_0000_2000, 64'h0000_0000_0000_3000);
    mem.put(40'h00_0000_2008, 64'h0);
    frag(40'h00_0000_2000, 0, 40'h05_0000_1001, 16'h0028);
    mem.put(40'h00_0000_3000, 64'h0);
    mem.put(40'h00_0000_3008, 64'h0);
    frag(40'h00_0000_3000, 0, 40'h44_0000_0000, 16'h0028);
    start(40'h00_0000_2000);
    send(64, 8'h80, 10'h3FF);
    wait_for(0);
    for (int k = 0; k < 64; k++) begin
      a = (k < 40) ? 40'h05_0000_1001 + 40'(k) : 40'h44_0000_0000 + 40'(k - 40);
      chkb(a, 8'h80 + 8'(k));
    end
    chk(mem.get(40'h00_0000_2008), 64'h0000_0000_A000_0000);
    // Every receiver flag set, runt clear, oversize from the limit.
    chk(mem.get(40'h00_0000_3008), 64'h0000_0000_CFFD_0040);
  endtask

  task automatic t_stall;
    rsd_pkg::rsd_mem_s held;
    lat <= 4'h3;
    mem.put(40'h00_0000_4000, 64'h0);
    mem.put(40'h00_0000_4008, 64'h0000_0000_8000_0000);
    frag(40'h00_0000_4000, 0, 40'h06_0000_0100, 16'h0008);
    start(40'h00_0000_4000);
    wait_for(1);
    chk({63'h0, stalled_o}, 64'h1);
    // A low enable must freeze the walker, its pending request included.
    @(posedge clk_i);
    en_i <= 1'b0;
    @(negedge clk_i);
    held = mem_o;
    repeat (6) @(negedge clk_i);
    chk({23'h0, mem_o.req, mem_o.addr}, {23'h0, held.req, held.addr});
    chk({63'h0, stalled_o}, 64'h1);
    @(posedge clk_i);
    en_i <= 1'b1;
    repeat (10) @(negedge clk_i);
    chk({63'h0, rx_ready_o}, 64'h0);
    mem.put(40'h00_0000_4008, 64'h0);
    send(2, 8'hC0, 10'h000);
    wait_for(0);
    chk({63'h0, stalled_o}, 64'h0);
    chkb(40'h06_0000_0101, 8'hC1);
    chk(mem.get(40'h00_0000_4008), 64'h0000_0000_E002_0002);
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // The longest scenario needs well under a tenth of this ceiling.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    failures = 0;
    num_checks = 0;
    cycles = 0;
    rst_n_i = 1'b0;
    en_i = 1'b1;
    start_i = 1'b0;
    list_head_i = 40'h0;
    frag_count_i = 4'h1;
    frame_size_limit_i = 16'h05DC;
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    rx_last_i = 1'b0;
    rx_info_i = '0;
    lat = 4'h0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_single();
    t_span();
    t_stall();
    tally_and_finish();
  end
endmodule

`default_nettype wire
